// File: hw/asf_pkg.sv
package asf_pkg;

   // ==========================================================
   // Register addresses and reset values.
   localparam logic [5:0]  ADDR_STATUS     = 6'h01;
   localparam logic [5:0]  ADDR_MODE       = 6'h02;
   localparam logic [15:0] MODE_RESET      = 16'h0510;
   localparam logic [15:0] STATUS_RESET    = 16'h0540;

   // ==========================================================
   // Status bit positions.
   localparam int BIT_LOCK     = 15;
   localparam int BIT_RESYNC   = 14;
   localparam int BIT_REGMAP   = 13;
   localparam int BIT_INCRC    = 12;
   localparam int BIT_CRCTYPE  = 11;
   localparam int BIT_RSTSEEN  = 10;
   localparam int BIT_WSIZE_LO = 8;
   localparam int BIT_TRIM     = 7;
   localparam int BIT_ISOFLT   = 6;

   // Mode bit positions.
   localparam int MBIT_CRCTYPE  = 11;
   localparam int MBIT_RESET    = 10;
   localparam int MBIT_WSIZE_LO = 8;

   // Field widths and counts.
   localparam int WSIZE_W      = 2;
   localparam int NUM_CH       = 3;
   localparam int BIT_READY_LO = 0;

   // ==========================================================
   // Register access request from the serial command decoder.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  addr;
      logic [15:0] wdata;
   } asf_req_s;

   // Events reported by the rest of the converter, one-cycle pulses or levels.
   typedef struct packed {
      logic       lockCmd;
      logic       unlockCmd;
      logic       resetCmd;
      logic       resync;
      logic       regMapFault;
      logic       inputCrcFault;
      logic       trimParityFault;
      logic       isoSideFault;
      logic [2:0] sampleReady;
   } asf_evt_s;

endpackage

// File: hw/asf_status_regs.sv
// Summary of operation
// - Lock bit 15 sets on lock command, clears on unlock command.
// - Bit 14 sets each time the converter resynchronizes.
// - Status read clears bits 14, 13, 12, 7, 6 and 2:0.
// - Bit 13 sets on a register map checksum fault.
// - Bit 12 sets on a checksum fault of received serial data.
// - Bit 11 mirrors checksum type; zero after reset.
// - Bit 10 sets on any reset source; resets to one.
// - Writing zero to mode reset bit clears status bit 10.
// - Bits 9:8 show sample word size; reset value 01b.
// - Bit 7 shows trim parity fault, sets again while fault persists.
// - Bit 6 shows isolated-side fault; resets to one.
// - Bits 2:0 show per-channel new data; reset to zero.
// - Mode register at address 02h resets to 0510h.
// - Status register at address 01h reads 0540h after reset.
// - Mode bits 9:8 hold the word size the status mirrors.
`timescale 1ns/10ps
`default_nettype none
module asf_status_regs
   import asf_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire asf_pkg::asf_req_s req,
   input  wire asf_pkg::asf_evt_s evt,
   output logic [15:0]           rdata,
   output logic                  rvalid,
   output logic [15:0]           modeConfig,
   output logic [15:0]           deviceStatus
);
   import asf_pkg::*;

   // ==========================================================
   // Decode
   function automatic logic hit(input asf_req_s r, input logic [5:0] a);
      hit = r.addr == a;
   endfunction

   logic statusRead;
   logic modeWrite;
   assign statusRead = req.rd && hit(req, ADDR_STATUS);
   assign modeWrite  = req.wr && hit(req, ADDR_MODE);

   logic lockFlag;
   logic resyncSeenFlag;
   logic regMapFlag;
   logic inCrcFlag;
   logic rstSeenFlag;
   logic trimFlag;
   logic isolatedSideFaultFlag;
   logic [2:0] sampleReadyFlags;

   // ==========================================================
   // Mode register, written by the host.
   always_ff @(posedge ref_clk) begin
      if (rst || evt.resetCmd) begin
         modeConfig <= MODE_RESET;
      end else if (modeWrite) begin
         modeConfig <= req.wdata;
      end
   end

   // Lock flag follows lock and unlock commands.
   always_ff @(posedge ref_clk) begin
      if (rst || evt.resetCmd) begin
         lockFlag <= 1'b0;
      end else if (evt.lockCmd) begin
         lockFlag <= 1'b1;
      end else if (evt.unlockCmd) begin
         lockFlag <= 1'b0;
      end
   end

   // Sticky fault flags; a set wins over the clearing read.
   always_ff @(posedge ref_clk) begin
      if (rst || evt.resetCmd) begin
         resyncSeenFlag        <= STATUS_RESET[BIT_RESYNC];
         regMapFlag            <= STATUS_RESET[BIT_REGMAP];
         inCrcFlag             <= STATUS_RESET[BIT_INCRC];
         trimFlag              <= STATUS_RESET[BIT_TRIM];
         isolatedSideFaultFlag <= STATUS_RESET[BIT_ISOFLT];
      end else begin
         resyncSeenFlag <= evt.resync | (resyncSeenFlag & ~statusRead);
         regMapFlag     <= evt.regMapFault | (regMapFlag & ~statusRead);
         inCrcFlag      <= evt.inputCrcFault | (inCrcFlag & ~statusRead);
         trimFlag       <= evt.trimParityFault | (trimFlag & ~statusRead);
         isolatedSideFaultFlag <= evt.isoSideFault |
                                  (isolatedSideFaultFlag & ~statusRead);
      end
   end

   // Reset-occurred flag, cleared by the host writing zero to mode bit 10.
   always_ff @(posedge ref_clk) begin
      if (rst || evt.resetCmd) begin
         rstSeenFlag <= 1'b1;
      end else if (modeWrite && !req.wdata[MBIT_RESET]) begin
         rstSeenFlag <= 1'b0;
      end
   end

   // Per-channel new data flags, cleared by a status read.
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ready
         always_ff @(posedge ref_clk) begin
            if (rst || evt.resetCmd) begin
               sampleReadyFlags[ch] <= 1'b0;
            end else begin
               sampleReadyFlags[ch] <= evt.sampleReady[ch] |
                                      (sampleReadyFlags[ch] & ~statusRead);
            end
         end
      end
   endgenerate

   // Assembled status word.
   always_comb begin
      deviceStatus = '0;
      deviceStatus[BIT_LOCK]    = lockFlag;
      deviceStatus[BIT_RESYNC]  = resyncSeenFlag;
      deviceStatus[BIT_REGMAP]  = regMapFlag;
      deviceStatus[BIT_INCRC]   = inCrcFlag;
      deviceStatus[BIT_CRCTYPE] = modeConfig[MBIT_CRCTYPE];
      deviceStatus[BIT_RSTSEEN] = rstSeenFlag;
      deviceStatus[BIT_WSIZE_LO +: WSIZE_W] = modeConfig[MBIT_WSIZE_LO +: WSIZE_W];
      deviceStatus[BIT_TRIM]    = trimFlag;
      deviceStatus[BIT_ISOFLT]  = isolatedSideFaultFlag;
      deviceStatus[BIT_READY_LO +: NUM_CH] = sampleReadyFlags;
   end

   // Read data, registered; unmapped addresses read zero.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata  <= '0;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (statusRead) begin
            rdata <= deviceStatus;
         end else if (req.rd && hit(req, ADDR_MODE)) begin
            rdata <= modeConfig;
         end else begin
            rdata <= '0;
         end
      end
   end

   // ==========================================================
   // Assertions
   property p_lock;
      @(posedge ref_clk) disable iff (rst)
         evt.lockCmd && !evt.resetCmd |=> lockFlag;
   endproperty
   a_lock: assert property (p_lock) else $error("lock not set");

   property p_resync;
      @(posedge ref_clk) disable iff (rst)
         evt.resync && !evt.resetCmd |=> deviceStatus[BIT_RESYNC];
   endproperty
   a_resync: assert property (p_resync) else $error("resync lost");

   property p_clear;
      @(posedge ref_clk) disable iff (rst)
         statusRead && !evt.resync && !evt.resetCmd |=> !resyncSeenFlag;
   endproperty
   a_clear: assert property (p_clear) else $error("read did not clear");

   property p_regmap;
      @(posedge ref_clk) disable iff (rst)
         evt.regMapFault && !evt.resetCmd |=> regMapFlag;
   endproperty
   a_regmap: assert property (p_regmap) else $error("map fault lost");

   property p_incrc;
      @(posedge ref_clk) disable iff (rst)
         evt.inputCrcFault && !evt.resetCmd |=> inCrcFlag;
   endproperty
   a_incrc: assert property (p_incrc) else $error("crc fault lost");

   property p_rstack;
      @(posedge ref_clk) disable iff (rst)
         modeWrite && !req.wdata[MBIT_RESET] && !evt.resetCmd |=> !rstSeenFlag;
   endproperty
   a_rstack: assert property (p_rstack) else $error("reset ack ignored");

   property p_after_reset;
      @(posedge ref_clk) $past(rst) |-> deviceStatus == STATUS_RESET
         && modeConfig == MODE_RESET;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("bad reset value");

   property p_mirror;
      @(posedge ref_clk) disable iff (rst)
         modeWrite && !evt.resetCmd |=>
            deviceStatus[BIT_WSIZE_LO +: WSIZE_W] == $past(req.wdata[MBIT_WSIZE_LO +: WSIZE_W]);
   endproperty
   a_mirror: assert property (p_mirror) else $error("word size mirror");

   property p_trim;
      @(posedge ref_clk) disable iff (rst)
         evt.trimParityFault && statusRead |=> trimFlag;
   endproperty
   a_trim: assert property (p_trim) else $error("trim fault lost");

   // Named steps shared by the properties below.
   sequence s_reset_cmd;
      evt.resetCmd;
   endsequence

   sequence s_quiet_status_read;
      statusRead && !evt.resetCmd && evt.sampleReady == '0;
   endsequence

   property p_unlock;
      @(posedge ref_clk) disable iff (rst)
         evt.unlockCmd && !evt.lockCmd && !evt.resetCmd |=> !lockFlag;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock not cleared");

   property p_isofault;
      @(posedge ref_clk) disable iff (rst)
         evt.isoSideFault && !evt.resetCmd |=> isolatedSideFaultFlag;
   endproperty
   a_isofault: assert property (p_isofault) else $error("isolated fault lost");

   // The reset command reloads the whole status and mode state.
   property p_reset_cmd;
      @(posedge ref_clk) disable iff (rst)
         s_reset_cmd |=> deviceStatus == STATUS_RESET && modeConfig == MODE_RESET;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command values");

   // A status read with no new data drops every ready bit.
   property p_ready_clear;
      @(posedge ref_clk) disable iff (rst)
         s_quiet_status_read |=> sampleReadyFlags == '0;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

   // The answer carries the status word as it stood at the read edge.
   property p_status_answer;
      @(posedge ref_clk) disable iff (rst)
         s_quiet_status_read |=> rvalid && rdata == $past(deviceStatus);
   endproperty
   a_status_answer: assert property (p_status_answer) else $error("status answer");

endmodule
`default_nettype wire

// File: dv/asf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module asf_host_model
   import asf_pkg::*;
(
   input  wire logic         ref_clk,
   output var asf_pkg::asf_req_s req
);
   import asf_pkg::*;
   initial req = '0;
   // Issues a one-cycle read strobe; the answer lands one edge later.
   task automatic rd(input logic [5:0] a);
      @(posedge ref_clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge ref_clk);
      req <= '0;
   endtask
   // Writes a word; the reset bit written low acknowledges a reset.
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '0;
   endtask
endmodule
`default_nettype wire

// File: dv/asf_status_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module asf_status_regs_tb_top;
   import asf_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   asf_req_s    req;
   asf_evt_s    evt     = '0;
   logic [15:0] rdata, modeConfig, deviceStatus, base;
   logic        rvalid, crc;
   logic [1:0]  ws;
   int          fails = 0;
   int          check_count = 0;
   // ==========================================================
   // Clock, host and design.
   always #5 ref_clk = ~ref_clk;
   asf_host_model asf_host_model_i (.ref_clk(ref_clk), .req(req));
   asf_status_regs asf_status_regs_i (.ref_clk(ref_clk), .rst(rst), .req(req), .evt(evt),
      .rdata(rdata), .rvalid(rvalid), .modeConfig(modeConfig), .deviceStatus(deviceStatus));
   // Compares one word.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Gives the event with sticky cause k raised.
   function automatic asf_evt_s evtFor(input int k);
      asf_evt_s e;
      e = '0;
      case (k)
         0: e.resync = 1'b1;
         1: e.regMapFault = 1'b1;
         2: e.inputCrcFault = 1'b1;
         3: e.trimParityFault = 1'b1;
         default: e.isoSideFault = 1'b1;
      endcase
      return e;
   endfunction
   // Gives the status bit that cause k sets.
   function automatic logic [15:0] bitFor(input int k);
      int pos[5] = '{BIT_RESYNC, BIT_REGMAP, BIT_INCRC, BIT_TRIM, BIT_ISOFLT};
      return 16'h0001 << pos[k];
   endfunction
   // Drives an event for one cycle.
   task automatic pulse(input asf_evt_s e);
      @(posedge ref_clk);
      evt <= e;
      @(posedge ref_clk);
      evt <= '0;
   endtask
   // Reads a register, checks the answer and that valid lasts one cycle.
   task automatic rdChk(input logic [5:0] a, input logic [15:0] exp);
      asf_host_model_i.rd(a);
      #1;
      chk({15'h0000, rvalid}, 16'h0001);
      chk(rdata, exp);
      @(posedge ref_clk);
      #1;
      chk({15'h0000, rvalid}, 16'h0000);
   endtask
   // Prints the counts and the verdict.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #20000;
      fails++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      void'($urandom(32'hab95));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk(deviceStatus, STATUS_RESET);
      chk(modeConfig, MODE_RESET);
      rdChk(ADDR_MODE, MODE_RESET);
      rdChk(6'h3f, 16'h0000);
      rdChk(ADDR_STATUS, STATUS_RESET);
      chk(deviceStatus, 16'h0500);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         ws  = i[1:0];
         crc = 1'($urandom);
         base = {4'h0, crc, 1'b0, ws, 8'h00};
         asf_host_model_i.wr(ADDR_MODE, base | 16'h0010);
         @(posedge ref_clk);
         #1;
         chk(modeConfig, base | 16'h0010);
         chk(deviceStatus, base);
      end
      asf_host_model_i.wr(6'h3f, 16'h0000);
      @(posedge ref_clk);
      #1;
      chk(modeConfig, base | 16'h0010);
      $display("test mode done");
      for (int k = 0; k < 5; k++) begin
         pulse(evtFor(k));
         #1;
         chk(deviceStatus, base | bitFor(k));
         rdChk(ADDR_STATUS, base | bitFor(k));
         chk(deviceStatus, base);
         fork
            asf_host_model_i.rd(ADDR_STATUS);
            pulse(evtFor(k));
         join
         #1;
         chk(deviceStatus, base | bitFor(k));
         rdChk(ADDR_STATUS, base | bitFor(k));
      end
      $display("test flags done");
      @(posedge ref_clk);
      evt <= evtFor(3);
      rdChk(ADDR_STATUS, base | 16'h0080);
      chk(deviceStatus, base | 16'h0080);
      @(posedge ref_clk);
      evt <= '0;
      rdChk(ADDR_STATUS, base | 16'h0080);
      chk(deviceStatus, base);
      pulse('{lockCmd: 1'b1, default: '0});
      rdChk(ADDR_STATUS, base | 16'h8000);
      pulse('{unlockCmd: 1'b1, default: '0});
      #1;
      chk(deviceStatus, base);
      pulse('{sampleReady: 3'b101, default: '0});
      rdChk(ADDR_STATUS, base | 16'h0005);
      pulse('{sampleReady: 3'b010, default: '0});
      rdChk(ADDR_STATUS, base | 16'h0002);
      pulse('{resetCmd: 1'b1, default: '0});
      #1;
      chk(deviceStatus, STATUS_RESET);
      chk(modeConfig, MODE_RESET);
      asf_host_model_i.wr(ADDR_MODE, base);
      pulse('{lockCmd: 1'b1, default: '0});
      #1;
      chk(deviceStatus, base | 16'h8040);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk(deviceStatus, STATUS_RESET);
      chk(modeConfig, MODE_RESET);
      rdChk(ADDR_STATUS, STATUS_RESET);
      $display("test events done");
      end_of_test();
   end
endmodule
`default_nettype wire
